/* File: hw/afc_host_codec.sv */
// host-side framer and deframer for the radio's serial byte link
// assumes a byte-wide UART/SPI core on the same clock drives the link ports
// Function
// - each frame starts with delimiter byte 0x7E
// - two length bytes follow, MSB first, counting frame data only
// - multi-byte values go big-endian
// - first frame data byte is the frame type
// - checksum is 0xFF minus low byte of frame data sum
// - frame good only if data sum plus checksum low byte is 0xFF
// - escaped mode escapes 0x7E, 0x7D, 0x11, 0x13 after the delimiter; the code escapes nothing, either way, when LINK_IS_SPI is set
// - escape is 0x7D then byte XOR 0x20; decode reverses it
// - length, data and checksum may be escaped, delimiter never
// - length and checksum cover unescaped data only
// - host tolerates unknown frame types rather than failing
`timescale 1ns/10ps
`default_nettype none
`include "afc_regs.svh"
module afc_host_codec (
    // clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    // configuration
    input  wire logic [1:0]              MODE,
    input  wire logic                    LINK_IS_SPI,
    // frame send request
    input  wire logic                    TX_REQ,
    input  wire logic [15:0]             TX_LEN,
    input  wire logic [7:0]              TX_TYPE,
    output var  logic                    TX_BUSY,
    // send data bytes
    output var  logic                    TX_DREQ,
    input  wire logic                    TX_DVALID,
    input  wire logic [7:0]              TX_DATA,
    // link toward the device
    output var  afc_pkg::afc_link_byte_t LINK_TX,
    input  wire logic                    LINK_TX_READY,
    input  wire afc_pkg::afc_link_byte_t LINK_RX,
    // received frame
    output var  afc_pkg::afc_rx_byte_t   RX_BYTE,
    output var  afc_pkg::afc_rx_end_t    RX_END
);
    import afc_pkg::*;

    function automatic logic needs_esc(input logic [7:0] b);
        needs_esc = (b == `AFC_DELIM) || (b == `AFC_ESC) || (b == `AFC_XON) || (b == `AFC_XOFF);
    endfunction

    afc_tx_state_t  t_state_reg;
    afc_tx_state_t  t_state_next;
    afc_rx_state_t  r_state_reg;
    afc_rx_state_t  r_state_next;
    logic [15:0]    t_len_reg;
    logic [15:0]    t_cnt_reg;
    logic [7:0]     t_type_reg;
    logic [7:0]     t_sum_reg;
    logic           req_out_reg;
    logic           pend_reg;
    logic [7:0]     pend_data_reg;
    logic [7:0]     r_lenh_reg;
    logic [15:0]    r_cnt_reg;
    logic [7:0]     r_sum_reg;
    logic           r_esc_reg;
    logic           r_first_reg;

    // mode decode, escaping blocked on SPI
    wire trans_on = (MODE == `AFC_MODE_TRANS);
    wire esc_on   = (MODE == `AFC_MODE_ESC) && !LINK_IS_SPI;

    // transmit side
    wire       emit_free = !LINK_TX.valid || (LINK_TX_READY && !pend_reg);
    wire       t_ctrl    = (t_state_reg == T_DELIM) || (t_state_reg == T_LENH) || (t_state_reg == T_LENL)
                           || (t_state_reg == T_TYPE) || (t_state_reg == T_SUM);
    wire       take      = TX_DVALID && req_out_reg;
    wire       emit_go   = (t_ctrl && emit_free) || take;
    wire [7:0] chk_byte  = `AFC_SUM_OK - t_sum_reg;
    wire [7:0] emit_raw  = (t_state_reg == T_DELIM) ? `AFC_DELIM :
                           (t_state_reg == T_LENH)  ? t_len_reg[15:8] :
                           (t_state_reg == T_LENL)  ? t_len_reg[7:0] :
                           (t_state_reg == T_TYPE)  ? t_type_reg :
                           (t_state_reg == T_SUM)   ? chk_byte : TX_DATA;
    // delimiter and transparent bytes are never escaped
    wire       emit_esc  = esc_on && (t_state_reg != T_DELIM) && (t_state_reg != T_RAW)
                           && needs_esc(emit_raw);
    // leaving transparent mode withdraws an unanswered byte request, else the framer never idles
    wire       raw_leave = (t_state_reg == T_RAW) && !trans_on;
    wire       ask       = ((t_state_reg == T_DATA) || ((t_state_reg == T_RAW) && trans_on))
                           && !LINK_TX.valid && !req_out_reg;
    wire       t_sum_add = emit_go && ((t_state_reg == T_TYPE) || (t_state_reg == T_DATA));

    always_comb begin
        t_state_next = t_state_reg;
        case (t_state_reg)
            T_IDLE:  begin
                if (trans_on) begin
                    t_state_next = T_RAW;
                end else if (TX_REQ) begin
                    t_state_next = T_DELIM;
                end
            end
            T_RAW:   begin
                if (raw_leave) begin
                    t_state_next = T_IDLE;
                end
            end
            T_DELIM: if (emit_free) t_state_next = T_LENH;
            T_LENH:  if (emit_free) t_state_next = T_LENL;
            T_LENL:  if (emit_free) t_state_next = (t_cnt_reg == 16'h0000) ? T_SUM : T_TYPE;
            T_TYPE:  if (emit_free) t_state_next = (t_cnt_reg == 16'h0001) ? T_SUM : T_DATA;
            T_DATA:  if (take && t_cnt_reg == 16'h0001) t_state_next = T_SUM;
            T_SUM:   if (emit_free) t_state_next = T_IDLE;
            default: t_state_next = T_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            t_state_reg <= T_IDLE;
            t_len_reg   <= 16'h0000;
            t_cnt_reg   <= 16'h0000;
            t_type_reg  <= 8'h00;
            t_sum_reg   <= 8'h00;
            req_out_reg <= 1'b0;
            TX_DREQ     <= 1'b0;
            TX_BUSY     <= 1'b0;
        end else begin
            t_state_reg <= t_state_next;
            TX_BUSY     <= (t_state_next != T_IDLE);
            TX_DREQ     <= ask;
            req_out_reg <= ask || (req_out_reg && !take && !raw_leave);
            if (t_state_reg == T_IDLE && TX_REQ && !trans_on) begin
                t_len_reg  <= TX_LEN;
                t_cnt_reg  <= TX_LEN;
                t_type_reg <= TX_TYPE;
                t_sum_reg  <= 8'h00;
            end else if (t_sum_add) begin
                t_sum_reg <= t_sum_reg + emit_raw;
                t_cnt_reg <= t_cnt_reg - 16'h0001;
            end
        end
    end

    // byte emitter, splits an escaped byte into two link bytes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            LINK_TX       <= '0;
            pend_reg      <= 1'b0;
            pend_data_reg <= 8'h00;
        end else if (emit_go) begin
            LINK_TX.valid <= 1'b1;
            LINK_TX.data  <= emit_esc ? `AFC_ESC : emit_raw;
            pend_reg      <= emit_esc;
            pend_data_reg <= emit_raw ^ `AFC_ESC_XOR;
        end else if (LINK_TX.valid && LINK_TX_READY) begin
            LINK_TX.valid <= pend_reg;
            LINK_TX.data  <= pend_data_reg;
            pend_reg      <= 1'b0;
        end
    end

    // receive side; status frames from the device decode like any other frame
    wire       rv       = LINK_RX.valid;
    wire       r_hunt   = (r_state_reg == R_HUNT);
    wire       is_delim = (LINK_RX.data == `AFC_DELIM);
    wire       resync   = esc_on && rv && is_delim && !r_hunt;
    wire       esc_mark = esc_on && rv && !r_hunt && !r_esc_reg && (LINK_RX.data == `AFC_ESC);
    wire [7:0] r_byte   = r_esc_reg ? (LINK_RX.data ^ `AFC_ESC_XOR) : LINK_RX.data;
    wire       got      = rv && !trans_on && !r_hunt && !resync && !esc_mark;
    wire [7:0] r_check  = r_sum_reg + r_byte;
    wire       r_good   = (r_check == `AFC_SUM_OK);
    wire       is_data  = got && (r_state_reg == R_DATA);
    wire       is_end   = got && (r_state_reg == R_SUM);

    always_comb begin
        r_state_next = r_state_reg;
        case (r_state_reg)
            R_HUNT:  if (rv && is_delim && !trans_on) r_state_next = R_LENH;
            R_LENH:  if (got) r_state_next = R_LENL;
            R_LENL:  if (got) r_state_next = ({r_lenh_reg, r_byte} == 16'h0000) ? R_SUM : R_DATA;
            R_DATA:  if (got && r_cnt_reg == 16'h0001) r_state_next = R_SUM;
            R_SUM:   if (got) r_state_next = R_HUNT;
            default: r_state_next = R_HUNT;
        endcase
        if (resync) begin
            r_state_next = R_LENH;
        end
        if (trans_on) begin
            r_state_next = R_HUNT;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r_state_reg <= R_HUNT;
            r_lenh_reg  <= 8'h00;
            r_cnt_reg   <= 16'h0000;
            r_sum_reg   <= 8'h00;
            r_esc_reg   <= 1'b0;
            RX_BYTE     <= '0;
            RX_END      <= '0;
        end else begin
            r_state_reg   <= r_state_next;
            r_esc_reg     <= esc_mark || (r_esc_reg && !(rv || resync));
            RX_BYTE.valid <= is_data || (trans_on && rv);
            RX_BYTE.data  <= trans_on ? LINK_RX.data : r_byte;
            RX_BYTE.first <= is_data && r_first_reg;
            RX_END.done   <= is_end;
            RX_END.good   <= is_end && r_good;
            RX_END.abort  <= resync;
            if (got && r_state_reg == R_LENH) begin
                r_lenh_reg <= r_byte;
            end
            if (got && r_state_reg == R_LENL) begin
                r_cnt_reg <= {r_lenh_reg, r_byte};
                r_sum_reg <= 8'h00;
            end else if (is_data) begin
                r_sum_reg <= r_check;
                r_cnt_reg <= r_cnt_reg - 16'h0001;
            end
        end
    end

    // first data byte of a frame is its type, passed on whatever its value
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r_first_reg <= 1'b0;
        end else if (got && r_state_reg == R_LENL) begin
            r_first_reg <= 1'b1;
        end else if (is_data || resync) begin
            r_first_reg <= 1'b0;
        end
    end

    a_delim_first: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (t_state_reg == T_DELIM && emit_free) |=> (LINK_TX.valid && LINK_TX.data == `AFC_DELIM && !pend_reg))
        else $error("frame did not open with the delimiter");
    a_len_order: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (t_state_reg == T_LENH && emit_free) |=> (t_state_reg == T_LENL)
            && (pend_reg ? (pend_data_reg ^ `AFC_ESC_XOR) == t_len_reg[15:8] : LINK_TX.data == t_len_reg[15:8]))
        else $error("length high byte not sent first");
    a_sum_value: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (t_state_reg == T_SUM && emit_free) |-> (emit_raw + t_sum_reg) == `AFC_SUM_OK)
        else $error("checksum byte wrong");
    a_esc_pair: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (LINK_TX.valid && pend_reg) |-> (LINK_TX.data == `AFC_ESC) && needs_esc(pend_data_reg ^ `AFC_ESC_XOR))
        else $error("escape pair malformed");
    a_spi_plain: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (LINK_IS_SPI && emit_go) |=> !pend_reg)
        else $error("escaping used on the SPI link");
    a_transp_pass: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (trans_on && rv) |=> (RX_BYTE.valid && RX_BYTE.data == $past(LINK_RX.data) && !RX_BYTE.first))
        else $error("transparent byte not passed");
    a_hunt_drop: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (!trans_on && r_hunt) |=> !RX_BYTE.valid && !RX_END.done)
        else $error("byte reported before delimiter");
    a_resync_abort: assert property (
        @(posedge CLK) disable iff (!RST_N)
        (resync && !trans_on) |=> (r_state_reg == R_LENH) && RX_END.abort && !RX_END.done)
        else $error("unescaped delimiter did not restart frame");
    a_check_good: assert property (
        @(posedge CLK) disable iff (!RST_N)
        RX_END.good |-> RX_END.done && $past(r_check) == `AFC_SUM_OK)
        else $error("frame marked good with bad checksum");
    a_raw_release: assert property (
        @(posedge CLK) disable iff (!RST_N)
        raw_leave |=> (t_state_reg == T_IDLE) && !req_out_reg && !TX_DREQ)
        else $error("transparent mode left with a byte request open");
endmodule
`default_nettype wire

/* File: common/afc_regs.svh */
// byte codes and mode values of the framed serial link
// assumes inclusion by the codec top only
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH
`define AFC_DELIM      8'h7E
`define AFC_ESC        8'h7D
`define AFC_XON        8'h11
`define AFC_XOFF       8'h13
`define AFC_ESC_XOR    8'h20
`define AFC_SUM_OK     8'hFF
`define AFC_MODE_TRANS 2'h0
`define AFC_MODE_FRAME 2'h1
`define AFC_MODE_ESC   2'h2
`endif

/* File: common/afc_pkg.sv */
// types shared by the host-side frame codec
// assumes afc_regs.svh is on the include path
`default_nettype none
package afc_pkg;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } afc_link_byte_t;

    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } afc_rx_byte_t;

    typedef struct packed {
        logic done;
        logic good;
        logic abort;
    } afc_rx_end_t;

    typedef enum logic [2:0] {
        T_IDLE  = 3'h0,
        T_RAW   = 3'h1,
        T_DELIM = 3'h2,
        T_LENH  = 3'h3,
        T_LENL  = 3'h4,
        T_TYPE  = 3'h5,
        T_DATA  = 3'h6,
        T_SUM   = 3'h7
    } afc_tx_state_t;

    typedef enum logic [2:0] {
        R_HUNT = 3'h0,
        R_LENH = 3'h1,
        R_LENL = 3'h2,
        R_DATA = 3'h3,
        R_SUM  = 3'h4
    } afc_rx_state_t;
endpackage
`default_nettype wire

/* File: testbench/afc_dev_model.sv */
// device-side model of the radio: paces the codec's bytes and sends it frames
// assumes the bench clock, and calls that land 1 ns after a rising edge
`timescale 1ns/10ps
`default_nettype none
module afc_dev_model (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // link
    input  wire logic                    slow,
    output var  logic                    ready,
    output var  afc_pkg::afc_link_byte_t rx
);
    import afc_pkg::*;
    int seed = 32'h79a7;
    initial rx = '0;
    initial ready = 1'b0;
    // a slow device stalls on random cycles so held bytes get exercised
    always @(posedge clk) begin
        ready <= rst_n && (!slow || 1'($random(seed)));
    end
    task automatic put(input logic [7:0] b, input logic esc);
        if (esc && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13)) begin
            @(posedge clk) #1 rx = {1'b1, 8'h7D};
            b = b ^ 8'h20;
        end
        @(posedge clk) #1 rx = {1'b1, b};
    endtask
    // a released line shows the inverse, never the last byte
    task automatic idle();
        @(posedge clk) #1 rx = {1'b0, ~rx.data};
    endtask
    task automatic frame(input logic [7:0] d[$], input logic esc, input logic bad);
        logic [7:0] sum;
        sum = 8'h00;
        @(posedge clk) #1 rx = {1'b1, 8'h7E};
        put(8'h00, esc);
        put(8'(d.size()), esc);
        foreach (d[i]) begin
            put(d[i], esc);
            sum = sum + d[i];
        end
        put((8'hFF - sum) ^ {7'h00, bad}, esc);
        idle();
    endtask
endmodule
`default_nettype wire

/* File: testbench/afc_host_codec_tb.sv */
// self-checking bench for the host frame codec against a device model
// assumes afc_pkg and the codec are compiled first
`timescale 1ns/10ps
`default_nettype none
module afc_host_codec_tb;
    import afc_pkg::*;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic [1:0]     mode = 2'h0;
    logic           is_spi = 1'b0;
    logic           tx_req = 1'b0;
    logic [15:0]    tx_len = 16'h0000;
    logic [7:0]     tx_type = 8'h00;
    logic           tx_dvalid = 1'b0;
    logic [7:0]     tx_data = 8'h00;
    logic           slow = 1'b0;
    logic           esc;
    logic           tx_busy;
    logic           tx_dreq;
    logic           ready;
    afc_link_byte_t link_tx;
    afc_link_byte_t link_rx;
    afc_rx_byte_t   rx_byte;
    afc_rx_end_t    rx_end;
    int             errors = 0;
    int             checks_done = 0;
    int             cycles = 0;
    int             seed = 32'h79a7;
    logic [8:0]     txq[$];
    logic [8:0]     rxq[$];
    logic [8:0]     endq[$];
    logic [7:0]     d[$];
    logic [7:0]     sp[4] = '{8'h7E, 8'h7D, 8'h11, 8'h13};
    always #10 clk = ~clk;
    afc_host_codec dut (.CLK(clk), .RST_N(rst_n), .MODE(mode), .LINK_IS_SPI(is_spi), .TX_REQ(tx_req),
        .TX_LEN(tx_len), .TX_TYPE(tx_type), .TX_BUSY(tx_busy), .TX_DREQ(tx_dreq), .TX_DVALID(tx_dvalid),
        .TX_DATA(tx_data), .LINK_TX(link_tx), .LINK_TX_READY(ready), .LINK_RX(link_rx), .RX_BYTE(rx_byte),
        .RX_END(rx_end));
    afc_dev_model dev (.clk(clk), .rst_n(rst_n), .slow(slow), .ready(ready), .rx(link_rx));
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            test_done();
        end
    end
    // an empty queue yields x, so any stray output is a mismatch
    always @(posedge clk) begin
        if (rst_n && link_tx.valid && ready) chk(link_tx, txq.size() ? txq.pop_front() : 'x, "link");
        if (rst_n && rx_byte.valid) chk({rx_byte.first, rx_byte.data}, rxq.size() ? rxq.pop_front() : 'x, "rx");
        if (rst_n && (rx_end.done || rx_end.abort))
            chk({6'h00, rx_end}, endq.size() ? endq.pop_front() : 'x, "end");
    end
    task automatic enc(input logic [7:0] b, input logic e);
        if (e && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13)) begin
            txq.push_back({1'b1, 8'h7D});
            b = b ^ 8'h20;
        end
        txq.push_back({1'b1, b});
    endtask
    task automatic serve(input logic [7:0] b);
        int k;
        k = 0;
        // the request pulse may already stand when the caller arrives
        while (!tx_dreq && k < 500) begin
            @(posedge clk) #1;
            k++;
        end
        tx_dvalid = 1'b1;
        tx_data = b;
        @(posedge clk) #1;
        tx_dvalid = 1'b0;
        tx_data = ~b;
    endtask
    task automatic drain();
        int k;
        k = 0;
        while ((txq.size() + rxq.size() + endq.size() > 0 || (tx_busy && mode != 2'h0)) && k < 3000) begin
            @(posedge clk) #1;
            k++;
        end
        chk(9'(txq.size() + rxq.size() + endq.size()), 9'h000, "left over");
    endtask
    task automatic send(input int n, input logic [7:0] t);
        logic [7:0] sum;
        logic [7:0] b;
        int         r;
        sum = 8'h00;
        // a request is only taken from idle, so wait out any frame or transparent spell
        while (tx_busy) @(posedge clk) #1;
        tx_req = 1'b1;
        tx_len = 16'(n);
        tx_type = t;
        @(posedge clk) #1;
        tx_req = 1'b0;
        chk({8'h00, tx_busy}, 9'h001, "busy");
        txq.push_back({1'b1, 8'h7E});
        enc(8'(n >> 8), esc);
        enc(8'(n), esc);
        if (n > 0) enc(t, esc);
        if (n > 0) sum = t;
        for (int i = 1; i < n; i++) begin
            r = $random(seed);
            b = r[3] ? sp[r[1:0]] : r[11:4];
            enc(b, esc);
            sum = sum + b;
            serve(b);
        end
        enc(8'hFF - sum, esc);
        drain();
    endtask
    task automatic expect_rx(input logic good, input logic abort);
        foreach (d[i]) rxq.push_back({i == 0, d[i]});
        endq.push_back({6'h00, !abort, good, abort});
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk) #1;
        // transparent: bytes pass both ways with no framing or escaping
        for (int i = 0; i < 4; i++) begin
            txq.push_back({1'b1, sp[i]});
            serve(sp[i]);
        end
        foreach (sp[i]) rxq.push_back({1'b0, sp[i]});
        foreach (sp[i]) dev.put(sp[i], 1'b0);
        dev.idle();
        drain();
        $display("test transparent done");
        // mode 3 of the loop is escape mode asked for over SPI, which must not escape
        for (int m = 1; m < 4; m++) begin
            mode = (m == 3) ? 2'h2 : 2'(m);
            is_spi = (m == 3);
            esc = (m == 2);
            slow = m[0];
            send(0, 8'h00);
            send(4, 8'h7D);
            send(7, 8'h90);
            dev.put(8'h55, 1'b0);
            dev.put(8'h11, 1'b0);
            d = '{8'h08, 8'h7E, 8'h13, 8'h7D};
            expect_rx(1'b1, 1'b0);
            dev.frame(d, esc, 1'b0);
            expect_rx(1'b0, 1'b0);
            dev.frame(d, esc, 1'b1);
            drain();
            $display("test framed mode %0d done", m);
        end
        // a bare delimiter mid-frame abandons the partial frame
        mode = 2'h2;
        is_spi = 1'b0;
        d = '{8'hA5, 8'h7E};
        expect_rx(1'b0, 1'b1);
        dev.put(8'h7E, 1'b0);
        dev.put(8'h00, 1'b1);
        dev.put(8'h05, 1'b1);
        foreach (d[i]) dev.put(d[i], 1'b1);
        d = '{8'h11, 8'h20};
        expect_rx(1'b1, 1'b0);
        dev.frame(d, 1'b1, 1'b0);
        drain();
        $display("test resync done");
        test_done();
    end
endmodule
`default_nettype wire
